// >>> rtl/ccu_pkg.sv
`default_nettype none
package ccu_pkg;
	// bus geometry
	localparam int          ADR_W          = 8;
	localparam int          DAT_W          = 32;
	localparam int          REG_W          = 8;
	// byte offsets of the register words
	localparam logic [7:0]  OFF_FLAGS      = 8'h00;
	localparam logic [7:0]  OFF_ENABLES    = 8'h04;
	localparam logic [7:0]  OFF_VAL_LO     = 8'h08;
	localparam logic [7:0]  OFF_VAL_HI     = 8'h0c;
	localparam logic [7:0]  OFF_CTRL       = 8'h10;
	localparam logic [7:0]  OFF_DEADBAND   = 8'h14;
	localparam logic [7:0]  OFF_T1_LO      = 8'h18;
	localparam logic [7:0]  OFF_T1_HI      = 8'h1c;
	localparam logic [7:0]  OFF_T1_CTRL    = 8'h20;
	// field positions
	localparam int          FLAG_UNIT_BIT  = 2;
	localparam int          CTRL_MODE_LSB  = 0;
	localparam int          CTRL_DUTY_LSB  = 4;
	localparam int          CTRL_CFG_LSB   = 6;
	// reset values
	localparam logic [7:0]  RST_FLAGS      = 8'h00;
	localparam logic [7:0]  RST_ENABLES    = 8'h00;
	localparam logic [7:0]  RST_CTRL       = 8'h00;
	localparam logic [7:0]  RST_DEADBAND   = 8'h00;
	localparam logic [7:0]  RST_T1_CTRL    = 8'h00;
	localparam logic [7:0]  RST_VALUE      = 8'h00;
	// mode select encodings
	localparam logic [3:0]  MODE_OFF       = 4'h0;
	localparam logic [3:0]  MODE_CMP_TOG   = 4'h2;
	localparam logic [3:0]  MODE_CAP_FALL  = 4'h4;
	localparam logic [3:0]  MODE_CAP_RISE  = 4'h5;
	localparam logic [3:0]  MODE_CAP_DIV4  = 4'h6;
	localparam logic [3:0]  MODE_CAP_DIV16 = 4'h7;
	localparam logic [3:0]  MODE_CMP_SET   = 4'h8;
	localparam logic [3:0]  MODE_CMP_CLR   = 4'h9;
	localparam logic [3:0]  MODE_CMP_SWI   = 4'ha;
	localparam logic [3:0]  MODE_CMP_SPEC  = 4'hb;
	localparam logic [1:0]  GRP_CAPTURE    = 2'h1;
	localparam logic [1:0]  GRP_COMPARE    = 2'h2;
	localparam logic [1:0]  GRP_PWM        = 2'h3;
	// output configuration encodings
	localparam logic [1:0]  CFG_SINGLE     = 2'h0;
	localparam logic [1:0]  CFG_FULL_FWD   = 2'h1;
	localparam logic [1:0]  CFG_HALF       = 2'h2;
	localparam logic [1:0]  CFG_FULL_REV   = 2'h3;
	// capture prescaler constants and terminal counts, zero duty value
	localparam logic [3:0]  PRESC_ZERO     = 4'h0;
	localparam logic [3:0]  PRESC_STEP     = 4'h1;
	localparam logic [1:0]  PRESC_DIV4_END = 2'h3;
	localparam logic [3:0]  PRESC_DIV16_END = 4'hf;
	localparam logic [9:0]  DUTY_ZERO      = 10'h000;
endpackage
`default_nettype wire

// >>> rtl/ccu_deadband.sv
`timescale 1ns/1ns
`default_nettype none
// rising edges are held back by delay_i cycles, falling edges pass at once
module ccu_deadband #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// signal path
	input  wire logic             level_i,
	input  wire logic [CNT_W-1:0] delay_i,
	output logic                  level_o
);
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q   <= '0;
			level_o <= 1'b0;
		end else if (ce_i) begin
			if (!level_i) begin
				cnt_q   <= '0;
				level_o <= 1'b0;
			end else if (!level_o) begin
				if (cnt_q == delay_i) begin
					level_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/ccu_unit.sv
`timescale 1ns/1ns
`default_nettype none
module ccu_unit (
	// clock, reset, enable
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      ce_i,
	// wishbone slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [ccu_pkg::ADR_W-1:0] adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [ccu_pkg::DAT_W-1:0] dat_i,
	output logic      [ccu_pkg::DAT_W-1:0] dat_o,
	output logic                           ack_o,
	// timer one
	input  wire logic [15:0]               timer_one_count_i,
	output logic      [7:0]                timer_one_control_o,
	output logic                           timer_one_reset_o,
	input  wire logic                      adc_enabled_i,
	output logic                           adc_start_o,
	// timer two
	input  wire logic [7:0]                timer_two_count_i,
	input  wire logic [7:0]                timer_two_period_i,
	input  wire logic [1:0]                timer_two_frac_i,
	input  wire logic                      timer_two_tick_i,
	output logic                           timer_two_clear_o,
	// pins
	input  wire logic                      unit_pin_i,
	output logic                           output_a_o,
	output logic                           output_b_o,
	output logic                           output_c_o,
	output logic                           output_d_o
);
	import ccu_pkg::*;

	logic [7:0] flags_q;
	logic [7:0] enables_q;
	logic [7:0] val_lo_q;
	logic [7:0] val_hi_q;
	logic [7:0] ctrl_q;
	logic [7:0] deadband_q;
	logic [7:0] t1_ctrl_q;
	logic [7:0] rd_data;
	logic       ack_q;
	logic       wr_en;
	logic       wr_lane;
	logic       ctrl_wr;
	logic       pin_s1_q;
	logic       pin_s2_q;
	logic       pin_s3_q;
	logic       rise_ev;
	logic       fall_ev;
	logic [3:0] presc_q;
	logic [3:0] mode;
	logic [1:0] cfg;
	logic       is_cap;
	logic       is_cmp;
	logic       is_pwm;
	logic       cap_edge;
	logic       cap_ev;
	logic       match;
	logic       match_q;
	logic       match_ev;
	logic       cmp_latch_q;
	logic       period_restart;
	logic [9:0] duty_next;
	logic [9:0] duty_buf;
	logic [9:0] duty_pos;
	logic [1:0] lat2_q;
	logic       pwm_q;
	logic       db_a;
	logic       db_b;
	logic       raw_a;
	logic       raw_b;
	logic       raw_c;
	logic       raw_d;

	assign mode   = ctrl_q[CTRL_MODE_LSB +: 4];
	assign cfg    = ctrl_q[CTRL_CFG_LSB +: 2];
	assign is_cap = (mode[3:2] == GRP_CAPTURE);
	assign is_cmp = (mode == MODE_CMP_TOG) || (mode[3:2] == GRP_COMPARE);
	assign is_pwm = (mode[3:2] == GRP_PWM);

	// bus slave: one wait state, writes land on the acknowledging edge
	assign ack_o   = ack_q;
	assign wr_en   = cyc_i && stb_i && we_i && ack_q;
	assign wr_lane = wr_en && sel_i[0];
	assign ctrl_wr = wr_lane && (adr_i == OFF_CTRL);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else if (ce_i) begin
			ack_q <= cyc_i && stb_i && !ack_q;
		end
	end

	always_comb begin
		case (adr_i)
			OFF_FLAGS:    rd_data = flags_q;
			OFF_ENABLES:  rd_data = enables_q;
			OFF_VAL_LO:   rd_data = val_lo_q;
			OFF_VAL_HI:   rd_data = val_hi_q;
			OFF_CTRL:     rd_data = ctrl_q;
			OFF_DEADBAND: rd_data = deadband_q;
			OFF_T1_LO:    rd_data = timer_one_count_i[7:0];
			OFF_T1_HI:    rd_data = timer_one_count_i[15:8];
			OFF_T1_CTRL:  rd_data = t1_ctrl_q;
			default:      rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (ce_i && cyc_i && stb_i && !ack_q) begin
			dat_o <= {{(DAT_W-REG_W){1'b0}}, rd_data};
		end
	end

	// plain software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enables_q  <= RST_ENABLES;
			ctrl_q     <= RST_CTRL;
			deadband_q <= RST_DEADBAND;
			t1_ctrl_q  <= RST_T1_CTRL;
		end else if (ce_i && wr_lane) begin
			case (adr_i)
				OFF_ENABLES:  enables_q  <= dat_i[7:0];
				OFF_CTRL:     ctrl_q     <= dat_i[7:0];
				OFF_DEADBAND: deadband_q <= dat_i[7:0];
				OFF_T1_CTRL:  t1_ctrl_q  <= dat_i[7:0];
				default:      ;
			endcase
		end
	end
	assign timer_one_control_o = t1_ctrl_q;

	// flag register: hardware set wins over a software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_q <= RST_FLAGS;
		end else if (ce_i) begin
			if (wr_lane && (adr_i == OFF_FLAGS)) begin
				flags_q <= dat_i[7:0];
			end
			if (cap_ev || match_ev) begin
				flags_q[FLAG_UNIT_BIT] <= 1'b1;
			end
		end
	end

	// pin synchroniser and edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end else if (ce_i) begin
			pin_s1_q <= unit_pin_i;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end
	assign rise_ev = pin_s2_q && !pin_s3_q;
	assign fall_ev = !pin_s2_q && pin_s3_q;

	// capture event selection
	assign cap_edge = (mode == MODE_CAP_FALL) ? fall_ev : rise_ev;
	always_comb begin
		case (mode)
			MODE_CAP_FALL:  cap_ev = fall_ev;
			MODE_CAP_RISE:  cap_ev = rise_ev;
			MODE_CAP_DIV4:  cap_ev = rise_ev && (presc_q[1:0] == PRESC_DIV4_END);
			MODE_CAP_DIV16: cap_ev = rise_ev && (presc_q == PRESC_DIV16_END);
			default:        cap_ev = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_q <= PRESC_ZERO;
		end else if (ce_i) begin
			if (!is_cap) begin
				presc_q <= PRESC_ZERO;
			end else if (cap_edge) begin
				presc_q <= presc_q + PRESC_STEP;
			end
		end
	end

	// compare match, edge of a sustained equality
	assign match    = is_cmp && ({val_hi_q, val_lo_q} == timer_one_count_i);
	assign match_ev = match && !match_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_q <= 1'b0;
		end else if (ce_i) begin
			match_q <= match;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_latch_q <= 1'b0;
		end else if (ce_i) begin
			if (ctrl_wr && (dat_i[7:0] == RST_CTRL)) begin
				cmp_latch_q <= 1'b0;
			end else if (ctrl_wr && (dat_i[3:0] == MODE_CMP_SET)) begin
				cmp_latch_q <= 1'b1;
			end else if (ctrl_wr && (dat_i[3:0] == MODE_CMP_CLR)) begin
				cmp_latch_q <= 1'b0;
			end else if (match_ev) begin
				case (mode)
					MODE_CMP_TOG: cmp_latch_q <= !cmp_latch_q;
					MODE_CMP_SET: cmp_latch_q <= 1'b1;
					MODE_CMP_CLR: cmp_latch_q <= 1'b0;
					default:      ;
				endcase
			end
		end
	end

	// special event trigger pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_one_reset_o <= 1'b0;
			adc_start_o       <= 1'b0;
		end else if (ce_i) begin
			timer_one_reset_o <= match_ev && (mode == MODE_CMP_SPEC);
			adc_start_o       <= match_ev && (mode == MODE_CMP_SPEC)
				&& adc_enabled_i;
		end
	end

	// shared value pair: capture, software, duty buffer
	assign period_restart    = timer_two_tick_i
		&& (timer_two_count_i == timer_two_period_i);
	assign timer_two_clear_o = period_restart;
	assign duty_next = {val_lo_q, ctrl_q[CTRL_DUTY_LSB +: 2]};
	assign duty_buf  = {val_hi_q, lat2_q};
	// next duty step: pin is high for exactly duty steps, as the flop lags one
	assign duty_pos  = {timer_two_count_i, timer_two_frac_i} + 10'h001;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			val_lo_q <= RST_VALUE;
			val_hi_q <= RST_VALUE;
			lat2_q   <= 2'h0;
		end else if (ce_i) begin
			if (wr_lane && (adr_i == OFF_VAL_LO)) begin
				val_lo_q <= dat_i[7:0];
			end
			if (wr_lane && (adr_i == OFF_VAL_HI) && !is_pwm) begin
				val_hi_q <= dat_i[7:0];
			end
			if (is_cap && cap_ev) begin
				val_lo_q <= timer_one_count_i[7:0];
				val_hi_q <= timer_one_count_i[15:8];
			end
			if (is_pwm && period_restart) begin
				val_hi_q <= val_lo_q;
				lat2_q   <= ctrl_q[CTRL_DUTY_LSB +: 2];
			end
		end
	end

	// pulse generator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_q <= 1'b0;
		end else if (ce_i) begin
			if (!is_pwm) begin
				pwm_q <= 1'b0;
			end else if (period_restart) begin
				pwm_q <= (duty_next != DUTY_ZERO);
			end else if (duty_pos == duty_buf) begin
				pwm_q <= 1'b0;
			end
		end
	end

	// deadband for the half-bridge pair
	ccu_deadband #(
		.CNT_W(REG_W)
	) u_db_a (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.level_i(pwm_q),
		.delay_i(deadband_q),
		.level_o(db_a)
	);

	ccu_deadband #(
		.CNT_W(REG_W)
	) u_db_b (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.level_i(is_pwm && !pwm_q),
		.delay_i(deadband_q),
		.level_o(db_b)
	);

	// output steering
	always_comb begin
		raw_a = 1'b0;
		raw_b = 1'b0;
		raw_c = 1'b0;
		raw_d = 1'b0;
		if (is_pwm) begin
			case (cfg)
				CFG_SINGLE:   raw_a = pwm_q;
				CFG_FULL_FWD: begin
					raw_a = 1'b1;
					raw_d = pwm_q;
				end
				CFG_HALF:     begin
					raw_a = db_a;
					raw_b = db_b;
				end
				CFG_FULL_REV: begin
					raw_c = 1'b1;
					raw_b = pwm_q;
				end
				default:      raw_a = 1'b0;
			endcase
		end else if (is_cmp) begin
			raw_a = cmp_latch_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_a_o <= 1'b0;
			output_b_o <= 1'b0;
			output_c_o <= 1'b0;
			output_d_o <= 1'b0;
		end else if (ce_i) begin
			output_a_o <= raw_a ^ (is_pwm && mode[1]);
			output_c_o <= raw_c ^ (is_pwm && mode[1]);
			output_b_o <= raw_b ^ (is_pwm && mode[0]);
			output_d_o <= raw_d ^ (is_pwm && mode[0]);
		end
	end

	// checks
	a_capture_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && is_cap && cap_ev |=>
		{val_hi_q, val_lo_q} == $past(timer_one_count_i))
		else $error("capture did not copy timer one");
	a_div16_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		cap_ev && mode == MODE_CAP_DIV16 |-> presc_q == 4'hf && rise_ev)
		else $error("sixteenth edge capture fired early");
	a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && (cap_ev || match_ev) |=> flags_q[FLAG_UNIT_BIT])
		else $error("unit flag not set on event");
	a_presc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !is_cap |=> presc_q == 4'h0)
		else $error("prescaler not cleared outside capture");
	a_set_preset: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ctrl_wr && dat_i[3:0] == MODE_CMP_SET |=> cmp_latch_q)
		else $error("set-on-match did not preset latch");
	a_zero_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ctrl_wr && dat_i[7:0] == 8'h00 |=> !cmp_latch_q ##1 !output_a_o)
		else $error("clearing control left latch high");
	a_swi_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && match_ev && mode == MODE_CMP_SWI && !ctrl_wr |=>
		$stable(cmp_latch_q))
		else $error("software interrupt compare moved latch");
	a_special_ev: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && match_ev && mode == MODE_CMP_SPEC |=>
		timer_one_reset_o && adc_start_o == $past(adc_enabled_i))
		else $error("special event trigger missing");
	a_duty_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && is_pwm && period_restart |=>
		val_hi_q == $past(val_lo_q) && pwm_q == ($past(duty_next) != 10'h000))
		else $error("period restart did not latch duty");
	a_duty_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && is_pwm && !period_restart
		&& ({timer_two_count_i, timer_two_frac_i} + 10'h001) == duty_buf |=>
		!pwm_q)
		else $error("pulse not cleared at duty match");
	a_hi_locked: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && is_pwm && !period_restart |=> $stable(val_hi_q))
		else $error("high buffer changed inside the period");

	c_capture: cover property (@(posedge clk_i) disable iff (rst_i)
		ce_i && is_cap && cap_ev);
	c_compare: cover property (@(posedge clk_i) disable iff (rst_i)
		ce_i && match_ev && mode == MODE_CMP_TOG);
	c_restart: cover property (@(posedge clk_i) disable iff (rst_i)
		ce_i && is_pwm && period_restart && duty_next != 10'h000);
	c_half_dead: cover property (@(posedge clk_i) disable iff (rst_i)
		is_pwm && cfg == CFG_HALF && $rose(db_b) && deadband_q != 8'h00);
endmodule
`default_nettype wire

// >>> tb/ccu_timer_model.sv
`timescale 1ns/1ns
`default_nettype none
// timer one and timer two as seen by the unit
module ccu_timer_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// timer one
	input  wire logic        run_i,
	input  wire logic        load_i,
	input  wire logic [15:0] load_val_i,
	input  wire logic        reset_req_i,
	output logic      [15:0] t1_count_o,
	// timer two
	input  wire logic        clear_req_i,
	output logic      [7:0]  t2_count_o,
	output logic      [1:0]  t2_frac_o,
	output logic             t2_tick_o
);
	// timer one steps on the unit clock only, never asynchronously
	always_ff @(posedge clk_i) begin
		if (rst_i || reset_req_i)
			t1_count_o <= 16'h0000;
		else if (load_i)
			t1_count_o <= load_val_i;
		else if (run_i)
			t1_count_o <= t1_count_o + 16'h0001;
	end
	// quarter-cycle phase
	always_ff @(posedge clk_i) begin
		if (rst_i)
			t2_frac_o <= 2'h0;
		else
			t2_frac_o <= t2_frac_o + 2'h1;
	end
	assign t2_tick_o = (t2_frac_o == 2'h3);
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_req_i)
			t2_count_o <= 8'h00;
		else if (t2_tick_o)
			t2_count_o <= t2_count_o + 8'h01;
	end
endmodule
`default_nettype wire

// >>> tb/capture_compare_pwm_unit_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module capture_compare_pwm_unit_tb_top;
	import ccu_pkg::*;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pin = 0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dw = 32'h0, dr;
	logic        ack, t1rst, adc_on = 1, adc_go, t2clr, tick, ld = 0;
	logic [15:0] t1, ldv = 16'h0;
	logic [7:0]  t1ctl, t2, pr = 8'h03;
	logic [1:0]  frac;
	logic        oa, ob, oc, od;
	int          error_cnt = 0, n_checks = 0, n_rst = 0, n_adc = 0;
	int          cnt[4], ovl;
	logic [31:0] v;
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n_rst += (t1rst === 1'b1);
		n_adc += (adc_go === 1'b1);
	end
	ccu_unit ccu_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(dw), .dat_o(dr), .ack_o(ack), .timer_one_count_i(t1),
		.timer_one_control_o(t1ctl), .timer_one_reset_o(t1rst),
		.adc_enabled_i(adc_on), .adc_start_o(adc_go),
		.timer_two_count_i(t2), .timer_two_period_i(pr),
		.timer_two_frac_i(frac), .timer_two_tick_i(tick),
		.timer_two_clear_o(t2clr), .unit_pin_i(pin), .output_a_o(oa),
		.output_b_o(ob), .output_c_o(oc), .output_d_o(od));
	ccu_timer_model ccu_timer_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.run_i(t1ctl[0]), .load_i(ld), .load_val_i(ldv),
		.reset_req_i(t1rst), .t1_count_o(t1), .clear_req_i(t2clr),
		.t2_count_o(t2), .t2_frac_o(frac), .t2_tick_o(tick));
	task results;
		if (error_cnt == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		dw <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		v = dr;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		if (n >= 50) begin
			error_cnt++;
			results();
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1, a, d);
	endtask
	task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(0, a, 8'h00);
		chk(nm, {24'h0, e}, v);
	endtask
	task t1_load(input logic [15:0] x);
		@(posedge clk_i);
		ld <= 1;
		ldv <= x;
		@(posedge clk_i);
		ld <= 0;
	endtask
	task s_regs;
		logic [7:0] offs[7] = '{OFF_FLAGS, OFF_ENABLES, OFF_VAL_LO,
			OFF_VAL_HI, OFF_CTRL, OFF_DEADBAND, OFF_T1_CTRL};
		foreach (offs[i])
			rd_chk("reset value", offs[i], 8'h00);
		wr(8'h30, 8'h5a);
		rd_chk("unmapped", 8'h30, 8'h00);
		wr(OFF_ENABLES, 8'ha5);
		rd_chk("enables", OFF_ENABLES, 8'ha5);
		t1_load(16'h1234);
		rd_chk("timer low", OFF_T1_LO, 8'h34);
		rd_chk("timer high", OFF_T1_HI, 8'h12);
	endtask
	// each pulse: timer 1000+k at the rise, 2000+k at the fall
	task cap(input logic [3:0] m, input int np, input logic clr,
		input logic fl, input logic [15:0] e);
		if (clr)
			wr(OFF_CTRL, 8'h00);
		wr(OFF_CTRL, {4'h0, m});
		wr(OFF_FLAGS, 8'h00);
		for (int k = 0; k < np; k++) begin
			t1_load(16'h1000 + 16'(k));
			pin <= 1;
			repeat (6) @(posedge clk_i);
			t1_load(16'h2000 + 16'(k));
			pin <= 0;
			repeat (6) @(posedge clk_i);
		end
		rd_chk("capture flag", OFF_FLAGS, {5'h0, fl, 2'h0});
		if (fl) begin
			rd_chk("capture low", OFF_VAL_LO, e[7:0]);
			rd_chk("capture high", OFF_VAL_HI, e[15:8]);
			wr(OFF_FLAGS, 8'h00);
			rd_chk("flag cleared", OFF_FLAGS, 8'h00);
		end
	endtask
	task cmp(input logic [3:0] m, input logic pre, input logic post);
		wr(OFF_CTRL, 8'h00);
		t1_load(16'h0038);
		wr(OFF_VAL_LO, 8'h40);
		wr(OFF_VAL_HI, 8'h00);
		wr(OFF_CTRL, {4'h0, m});
		wr(OFF_FLAGS, 8'h00);
		repeat (3) @(posedge clk_i);
		chk("preset", {31'h0, pre}, {31'h0, oa});
		n_rst = 0;
		n_adc = 0;
		wr(OFF_T1_CTRL, 8'h01);
		repeat (20) @(posedge clk_i);
		wr(OFF_T1_CTRL, 8'h00);
		rd_chk("match flag", OFF_FLAGS, 8'h04);
		chk("pin after match", {31'h0, post}, {31'h0, oa});
		chk("timer resets", (m == MODE_CMP_SPEC), n_rst);
		chk("converter starts", (m == MODE_CMP_SPEC) && adc_on, n_adc);
	endtask
	task measure;
		cnt = '{0, 0, 0, 0};
		ovl = 0;
		repeat (16) begin
			@(posedge clk_i);
			#1;
			cnt[0] += oa;
			cnt[1] += ob;
			cnt[2] += oc;
			cnt[3] += od;
			ovl += (oa & ob);
		end
	endtask
	// period is 16 clocks with pr at 8'h03 and 8 clocks with pr at 8'h01; a negative expectation skips that output
	task pwm(input logic [7:0] ctl, input logic [7:0] lo, input int e[4]);
		wr(OFF_VAL_LO, lo);
		wr(OFF_CTRL, ctl);
		repeat (40) @(posedge clk_i);
		measure();
		foreach (e[i])
			if (e[i] >= 0)
				chk("high cycles", e[i], cnt[i]);
		rd_chk("duty buffer", OFF_VAL_HI, lo);
		wr(OFF_VAL_HI, 8'h55);
		rd_chk("buffer read-only", OFF_VAL_HI, lo);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		s_regs();
		cap(MODE_CAP_RISE, 2, 1, 1, 16'h1001);
		cap(MODE_CAP_FALL, 1, 1, 1, 16'h2000);
		cap(MODE_CAP_DIV4, 3, 1, 0, 16'h0000);
		cap(MODE_CAP_DIV4, 1, 0, 1, 16'h1000);
		cap(MODE_CAP_DIV4, 3, 1, 0, 16'h0000);
		cap(MODE_CAP_DIV4, 1, 1, 0, 16'h0000);
		cap(MODE_CAP_DIV16, 15, 1, 0, 16'h0000);
		cap(MODE_CAP_DIV16, 1, 0, 1, 16'h1000);
		cap(MODE_CAP_DIV4, 3, 1, 0, 16'h0000);
		cap(MODE_CAP_DIV16, 13, 0, 1, 16'h100c);
		cmp(MODE_CMP_TOG, 0, 1);
		cmp(MODE_CMP_SET, 1, 1);
		wr(OFF_CTRL, 8'h00);
		wr(OFF_CTRL, {4'h0, MODE_CMP_SWI});
		repeat (3) @(posedge clk_i);
		chk("latch cleared", 32'h0, {31'h0, oa});
		wr(OFF_CTRL, {4'h0, MODE_CMP_SET});
		wr(OFF_CTRL, {4'h0, MODE_CMP_CLR});
		repeat (3) @(posedge clk_i);
		chk("clear preset", 32'h0, {31'h0, oa});
		cmp(MODE_CMP_CLR, 0, 0);
		cmp(MODE_CMP_SWI, 0, 0);
		cmp(MODE_CMP_SPEC, 0, 0);
		adc_on <= 0;
		cmp(MODE_CMP_SPEC, 0, 0);
		adc_on <= 1;
		wr(OFF_CTRL, 8'h00);
		wr(OFF_DEADBAND, 8'h02);
		pwm(8'h2c, 8'h01, '{6, -1, -1, -1});
		pwm(8'h0c, 8'h00, '{0, -1, -1, -1});
		pwm(8'h3c, 8'hff, '{16, -1, -1, -1});
		pwm(8'h2e, 8'h01, '{10, -1, -1, -1});
		pwm(8'h6c, 8'h01, '{16, 0, 0, 6});
		pwm(8'hec, 8'h01, '{0, 6, 16, 0});
		pwm(8'hac, 8'h01, '{-1, -1, -1, -1});
		chk("bridge difference", 32'd4, 32'(cnt[1] - cnt[0]));
		chk("bridge overlap", 32'd0, 32'(ovl));
		pr <= 8'h01;
		repeat (1100) @(posedge clk_i);
		pwm(8'h2c, 8'h01, '{12, -1, -1, -1});
		results();
	end
endmodule
`default_nettype wire
